// File: src/dcc_map.svh
/*
 * Offsets, field positions, reset values and timing counts of the disk command
 * control decoder and status builder. Assumes a 25 MHz clock.
 */
`ifndef DCC_MAP_SVH
`define DCC_MAP_SVH

// control byte fields
`define DCC_CTL_RETRY_DIS   7
`define DCC_CTL_ECC_DIS     6
`define DCC_CTL_FMT_BUF     6
`define DCC_CTL_CONV        5
`define DCC_CTL_STEP_HI     2
`define DCC_CTL_STEP_LO     0
// status byte fields
`define DCC_ST_ERR          1
`define DCC_ST_REC_LO       2
`define DCC_ST_LUN          5
`define DCC_ST_RESET        8'h00
// retry plan, conversion head count and format pattern
`define DCC_RETRY_HALF      4
`define DCC_HEADS_CONV      16
`define DCC_FMT_PATTERN     8'h6c
// step times in ns and cycles at 40 ns
`define DCC_CLK_NS          40
`define DCC_STEP_10US_NS    10000
`define DCC_STEP_25US_NS    25000
`define DCC_STEP_50US_NS    50000
`define DCC_STEP_70US_NS    70000
`define DCC_STEP_200US_NS   200000
`define DCC_STEP_3MS_NS     3000000
`define DCC_CYC(ns)         (((ns) + `DCC_CLK_NS - 1) / `DCC_CLK_NS)

`endif

// File: src/dcc_pkg.sv
/*
 * Types of the disk command control decoder.
 * Assumes dcc_map.svh holds the field positions, reset values and timing counts.
 */
package dcc_pkg;
	// decoded control byte
	typedef struct packed {
		logic       retry_dis;
		logic       opt6;
		logic       conv;
		logic [2:0] step_code;
	} dcc_ctl_t;

	// media result of one block attempt
	typedef struct packed {
		logic ok;
		logic correctable;
		logic uncorrectable;
		logic other_err;
	} dcc_res_t;

	// recovery class reported in status bits 3:2
	typedef enum logic [1:0] {
		DCC_REC_NONE = 2'b00,
		DCC_REC_ONE  = 2'b01,
		DCC_REC_MANY = 2'b10,
		DCC_REC_ECC  = 2'b11
	} dcc_rec_t;
endpackage : dcc_pkg

// File: src/dcc_step_timer.sv
/*
 * Step pulse rate generator: emits a one-cycle step enable at the period
 * chosen by the step code. Assumes a 25 MHz clock and synchronous reset.
 */
`timescale 1ns/10ps
`include "dcc_map.svh"
module dcc_step_timer
	import dcc_pkg::*;
#(
	parameter int unsigned SLOW_CYC = `DCC_CYC(`DCC_STEP_3MS_NS)
) (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       run,
	input  wire logic [2:0] step_code,
	output logic            step_en,
	output logic            buffered
);
	localparam int unsigned W = 17;
	logic [W-1:0] cnt_r;
	logic [W-1:0] period;

	// period lookup; slow codes take the parameter so simulation can shorten it
	always_comb begin
		buffered = 1'b1;
		case (step_code)
			3'b000:  period = W'(`DCC_CYC(`DCC_STEP_10US_NS));
			3'b011:  period = W'(`DCC_CYC(`DCC_STEP_25US_NS));
			3'b010:  period = W'(`DCC_CYC(`DCC_STEP_50US_NS));
			3'b101:  period = W'(`DCC_CYC(`DCC_STEP_200US_NS));
			3'b100:  period = W'(`DCC_CYC(`DCC_STEP_70US_NS));
			default: begin
				period   = W'(SLOW_CYC);
				buffered = 1'b0;
			end
		endcase
	end

	// free counter restarts whenever stepping is idle
	always_ff @(posedge clock) begin
		if (!rst_n || !run) begin
			cnt_r   <= '0;
			step_en <= 1'b0;
		end else if (cnt_r >= period - W'(1)) begin
			cnt_r   <= '0;
			step_en <= 1'b1;
		end else begin
			cnt_r   <= cnt_r + W'(1);
			step_en <= 1'b0;
		end
	end

	property p_step_gap;
		@(posedge clock) disable iff (!rst_n)
		step_en && run && step_code == 3'b000 ##1 (run && step_code == 3'b000)[*8]
			|-> !step_en;
	endproperty
	a_step_gap: assert property (p_step_gap) else $error("10 us step came early");
endmodule : dcc_step_timer

// File: src/dcc_ctl_status.sv
/*
 * Control byte decoder, retry sequencer and completion status builder.
 * Assumes the media engine reports one result per attempt and the command
 * block parser strobes the control byte as the last byte of the block.
 */
`timescale 1ns/10ps
`include "dcc_map.svh"
module dcc_ctl_status
	import dcc_pkg::*;
#(
	parameter int unsigned SLOW_CYC = `DCC_CYC(`DCC_STEP_3MS_NS)
) (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       ctl_byte_vld,
	input  wire logic [7:0] ctl_byte,
	input  wire logic       cmd_is_read,
	input  wire logic       cmd_is_format,
	input  wire logic       cmd_has_retry,
	input  wire logic       cmd_lun,
	input  wire logic [5:0] sector_in,
	input  wire logic [4:0] head_in,
	input  wire logic       sectors_per_track_jumper_high,
	input  wire logic       sectors_per_track_jumper_low,
	input  wire logic       res_vld,
	input  wire dcc_res_t   res,
	input  wire logic       last_block,
	input  wire logic       seek_run,
	output logic            retry_req,
	output logic            recal_req,
	output logic            next_block,
	output logic            send_corrected,
	output logic            fmt_from_buf,
	output logic            host_data_en,
	output logic [7:0]      fmt_byte,
	output logic [11:0]     lba_out,
	output logic            step_en,
	output logic            step_buffered,
	output logic            done,
	output logic            status_vld,
	output logic [7:0]      completion_status_byte
);
	typedef enum logic [2:0] {
		DCC_IDLE, DCC_WAIT, DCC_RECAL, DCC_END
	} dcc_state_t;

	dcc_ctl_t   ctl_r;
	dcc_state_t state_r;
	logic [3:0] tries_r;
	logic       err_r;
	dcc_rec_t   rec_r;
	logic       lun_r;
	logic       step_pulse;
	logic       step_buf;

	// worst recovery class, ecc outranks any retry count
	function automatic dcc_rec_t worst(input dcc_rec_t a, input dcc_rec_t b);
		worst = (a > b) ? a : b;
	endfunction

	// sectors per track from the two jumpers
	function automatic logic [5:0] spt(input logic hi, input logic lo);
		case ({hi, lo})
			2'b00:   spt = 6'h11;
			2'b01:   spt = 6'h1a;
			2'b10:   spt = 6'h20;
			default: spt = 6'h22;
		endcase
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// control byte capture; it closes the block so it is taken on its strobe
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctl_r <= '0;
			lun_r <= 1'b0;
		end else if (ctl_byte_vld) begin
			ctl_r.retry_dis <= ctl_byte[`DCC_CTL_RETRY_DIS];
			ctl_r.opt6      <= ctl_byte[`DCC_CTL_ECC_DIS];
			ctl_r.conv      <= ctl_byte[`DCC_CTL_CONV];
			ctl_r.step_code <= ctl_byte[`DCC_CTL_STEP_HI:`DCC_CTL_STEP_LO];
			lun_r           <= cmd_lun;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// format data source: buffer or fixed pattern, host data shut off for buffer format
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			fmt_from_buf <= 1'b0;
			host_data_en <= 1'b1;
			fmt_byte     <= 8'h00;
		end else begin
			fmt_from_buf <= cmd_is_format && ctl_r.opt6;
			host_data_en <= !(cmd_is_format && ctl_r.opt6);
			fmt_byte     <= `DCC_FMT_PATTERN;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// sector address: head-major conversion at 16 heads, or pass through;
	// limited to 12 bits of linear sector since cylinder is out of scope
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			lba_out <= 12'h000;
		end else if (ctl_r.conv) begin
			lba_out <= 12'(head_in) * 12'(spt(sectors_per_track_jumper_high,
				sectors_per_track_jumper_low)) + 12'(sector_in);
		end else begin
			lba_out <= {6'h00, sector_in};
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// retry sequencer: four retries, recalibrate, four more
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_r        <= DCC_IDLE;
			tries_r        <= 4'h0;
			err_r          <= 1'b0;
			rec_r          <= DCC_REC_NONE;
			retry_req      <= 1'b0;
			recal_req      <= 1'b0;
			next_block     <= 1'b0;
			send_corrected <= 1'b0;
			done           <= 1'b0;
		end else begin
			retry_req      <= 1'b0;
			recal_req      <= 1'b0;
			next_block     <= 1'b0;
			send_corrected <= 1'b0;
			done           <= 1'b0;
			case (state_r)
				DCC_IDLE: begin
					if (ctl_byte_vld) begin
						state_r <= DCC_WAIT;
						tries_r <= 4'h0;
						err_r   <= 1'b0;
						rec_r   <= DCC_REC_NONE;
					end
				end
				DCC_WAIT: begin
					if (res_vld) begin
						if (res.ok || (res.correctable && !ctl_r.opt6 && cmd_is_read)) begin
							// success, possibly after correction
							if (res.correctable) begin
								send_corrected <= 1'b1;
								rec_r <= worst(rec_r, DCC_REC_ECC);
							end else if (tries_r == 4'h1) begin
								rec_r <= worst(rec_r, DCC_REC_ONE);
							end else if (tries_r > 4'h1) begin
								rec_r <= worst(rec_r, DCC_REC_MANY);
							end
							tries_r <= 4'h0;
							if (last_block) begin
								state_r <= DCC_END;
							end else begin
								next_block <= 1'b1;
							end
						end else if (ctl_r.retry_dis || !cmd_has_retry) begin
							// a correctable read block still reaches the host
							send_corrected <= res.correctable && cmd_is_read;
							err_r   <= 1'b1;
							state_r <= DCC_END;
						end else if (tries_r == 4'(2 * `DCC_RETRY_HALF)) begin
							// retries exhausted; a correctable block is still sent
							send_corrected <= res.correctable;
							err_r   <= 1'b1;
							state_r <= DCC_END;
						end else if (tries_r == 4'(`DCC_RETRY_HALF)) begin
							recal_req <= 1'b1;
							tries_r   <= tries_r + 4'h1;
							state_r   <= DCC_RECAL;
						end else begin
							retry_req <= 1'b1;
							tries_r   <= tries_r + 4'h1;
						end
					end
				end
				DCC_RECAL: begin
					// recalibration done when its result arrives, then retry
					if (res_vld) begin
						retry_req <= 1'b1;
						state_r   <= DCC_WAIT;
					end
				end
				DCC_END: begin
					done    <= 1'b1;
					state_r <= DCC_IDLE;
				end
				default: state_r <= DCC_IDLE;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// status byte for the status phase; recovery bits only for reads
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			completion_status_byte <= `DCC_ST_RESET;
			status_vld             <= 1'b0;
		end else if (state_r == DCC_END) begin
			completion_status_byte <= 8'h00;
			completion_status_byte[`DCC_ST_ERR] <= err_r;
			completion_status_byte[`DCC_ST_LUN] <= lun_r;
			completion_status_byte[`DCC_ST_REC_LO +: 2] <=
				cmd_is_read ? rec_r : DCC_REC_NONE;
			status_vld <= 1'b1;
		end else if (ctl_byte_vld) begin
			status_vld <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// step rate, registered so outputs leave flip-flops
	dcc_step_timer #(
		.SLOW_CYC (SLOW_CYC)
	) u_step (
		.clock     (clock),
		.rst_n     (rst_n),
		.run       (seek_run),
		.step_code (ctl_r.step_code),
		.step_en   (step_pulse),
		.buffered  (step_buf)
	);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			step_en       <= 1'b0;
			step_buffered <= 1'b1;
		end else begin
			step_en       <= step_pulse;
			step_buffered <= step_buf;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// checks
	property p_no_retry;
		@(posedge clock) disable iff (!rst_n)
		state_r == DCC_WAIT && res_vld && !res.ok && !res.correctable && ctl_r.retry_dis
			|=> !retry_req && state_r == DCC_END ##1 done;
	endproperty
	a_no_retry: assert property (p_no_retry) else $error("retry despite disable");

	property p_recal_after_four;
		@(posedge clock) disable iff (!rst_n)
		recal_req |-> $past(tries_r) == 4'h4;
	endproperty
	a_recal_after_four: assert property (p_recal_after_four) else $error("recal misplaced");

	property p_max_tries;
		@(posedge clock) disable iff (!rst_n)
		retry_req |-> tries_r <= 4'h8;
	endproperty
	a_max_tries: assert property (p_max_tries) else $error("too many retries");

	property p_exhaust_err;
		@(posedge clock) disable iff (!rst_n)
		state_r == DCC_WAIT && res_vld && !res.ok && !res.correctable && tries_r == 4'h8
			|=> ##1 status_vld && completion_status_byte[1];
	endproperty
	a_exhaust_err: assert property (p_exhaust_err) else $error("exhausted without error");

	property p_zero_bits;
		@(posedge clock) disable iff (!rst_n)
		status_vld |-> completion_status_byte[7:6] == 2'b00
			&& !completion_status_byte[4] && !completion_status_byte[0];
	endproperty
	a_zero_bits: assert property (p_zero_bits) else $error("reserved status set");

	property p_done_status;
		@(posedge clock) disable iff (!rst_n)
		done |-> status_vld;
	endproperty
	a_done_status: assert property (p_done_status) else $error("no status at end");

	property p_fmt_src;
		@(posedge clock) disable iff (!rst_n)
		cmd_is_format && ctl_r.opt6 && $stable(ctl_r) |=> !host_data_en && fmt_from_buf;
	endproperty
	a_fmt_src: assert property (p_fmt_src) else $error("host data during buffer format");

	property p_pass;
		@(posedge clock) disable iff (!rst_n)
		!ctl_r.conv && !ctl_byte_vld |=> lba_out == {6'h00, $past(sector_in)};
	endproperty
	a_pass: assert property (p_pass) else $error("address altered");

	// retries issued for the current block; the budget restarts per block
	// because a successful retry moves on to the next one
	logic [3:0] chk_retries_r;
	always_ff @(posedge clock) begin
		if (!rst_n || next_block || (ctl_byte_vld && state_r == DCC_IDLE)) begin
			chk_retries_r <= 4'h0;
		end else if (retry_req) begin
			chk_retries_r <= chk_retries_r + 4'h1;
		end
	end

	property p_retry_budget;
		@(posedge clock) disable iff (!rst_n)
		retry_req |-> chk_retries_r < 4'h8;
	endproperty
	a_retry_budget: assert property (p_retry_budget) else $error("retry budget exceeded");

	// a data attempt that neither succeeded nor can be corrected
	sequence s_hard_fail;
		state_r == DCC_WAIT && res_vld && !res.ok && !res.correctable;
	endsequence

	// the command winds down: end state without new requests, then done
	sequence s_wind_down;
		state_r == DCC_END && !retry_req && !recal_req ##1 done;
	endsequence

	property p_no_retry_cmd;
		@(posedge clock) disable iff (!rst_n)
		s_hard_fail ##0 !cmd_has_retry |=> s_wind_down;
	endproperty
	a_no_retry_cmd: assert property (p_no_retry_cmd) else $error("retry not allowed");

	property p_recal_resume;
		@(posedge clock) disable iff (!rst_n)
		state_r == DCC_RECAL && res_vld |=> retry_req && state_r == DCC_WAIT;
	endproperty
	a_recal_resume: assert property (p_recal_resume) else $error("no retry after recal");

	property p_correct_send;
		@(posedge clock) disable iff (!rst_n)
		state_r == DCC_WAIT && res_vld && !res.ok && res.correctable && cmd_is_read
			&& !ctl_r.opt6 |=> send_corrected && !retry_req;
	endproperty
	a_correct_send: assert property (p_correct_send) else $error("corrected data not sent");

	property p_ok_status;
		@(posedge clock) disable iff (!rst_n)
		state_r == DCC_END && !err_r |=> status_vld && !completion_status_byte[`DCC_ST_ERR];
	endproperty
	a_ok_status: assert property (p_ok_status) else $error("error bit on success");

	property p_rec_read_only;
		@(posedge clock) disable iff (!rst_n)
		state_r == DCC_END && !cmd_is_read
			|=> completion_status_byte[`DCC_ST_REC_LO +: 2] == 2'b00;
	endproperty
	a_rec_read_only: assert property (p_rec_read_only) else $error("recovery bits on non-read");

	property p_lun_status;
		@(posedge clock) disable iff (!rst_n)
		state_r == DCC_END |=> completion_status_byte[`DCC_ST_LUN] == $past(lun_r);
	endproperty
	a_lun_status: assert property (p_lun_status) else $error("unit number wrong");
endmodule : dcc_ctl_status

// File: tb/dcc_media_model.sv
/*
 * Behavioural media engine and host side facing the control decoder.
 * Assumes go starts each command and the decoder requests every later attempt with retry_req, recal_req or next_block.
 */
`timescale 1ns/10ps
module dcc_media_model
	import dcc_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       go,
	input  wire logic [7:0] nblk,
	input  wire logic [7:0] nfail,
	input  wire dcc_res_t   fail_kind,
	input  wire logic       retry_req,
	input  wire logic       recal_req,
	input  wire logic       next_block,
	output logic            res_vld,
	output dcc_res_t        res,
	output logic            last_block
);
	logic [1:0] dly_r;
	logic       pend_r;
	logic       recal_r;
	logic [7:0] tries_r;
	logic [7:0] blk_r;

	////////////////////////////////////////////////////////////////////////////////
	// one result two cycles after each request; res toggles when not valid so
	// a stale value is never mistaken for a fresh one
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			res_vld <= 1'b0;
			pend_r  <= 1'b0;
			dly_r   <= 2'h0;
			recal_r <= 1'b0;
			tries_r <= 8'h00;
			blk_r   <= 8'h00;
			res     <= 4'h0;
		end else begin
			res_vld <= 1'b0;
			res     <= ~res;
			if (go || retry_req || recal_req || next_block) begin
				pend_r  <= 1'b1;
				dly_r   <= 2'h1;
				recal_r <= recal_req;
				if (go) begin
					tries_r <= 8'h00;
					blk_r   <= 8'h00;
				end else if (next_block) begin
					blk_r <= blk_r + 8'h01;
				end
			end else if (pend_r && dly_r != 2'h0) begin
				dly_r <= dly_r - 2'h1;
			end else if (pend_r) begin
				res_vld <= 1'b1;
				pend_r  <= 1'b0;
				// recalibration completion is not a data attempt
				if (!recal_r) tries_r <= tries_r + 8'h01;
				res <= (!recal_r && tries_r < nfail) ? fail_kind : 4'h8;
			end
		end
	end

	// last block once the requested block count is reached
	assign last_block = (blk_r + 8'h01 >= nblk);
endmodule : dcc_media_model

// File: tb/testbench.sv
/*
 * Self-checking bench for the control decoder and status builder.
 * Assumes the media model answers each attempt; step timer shortened to 20.
 */
`timescale 1ns/10ps
module testbench
	import dcc_pkg::*;
;
	logic clock = 1'b0, rst_n = 1'b0, ctl_byte_vld = 1'b0, cmd_is_read = 1'b0;
	logic has_retry = 1'b1;
	logic [7:0] nblk = 8'h01;
	logic cmd_is_format = 1'b0, cmd_lun = 1'b0, jh = 1'b0, jl = 1'b0, seek_run = 1'b0;
	logic go = 1'b0, res_vld, last_block, retry_req, recal_req, next_block, send_corrected;
	logic fmt_from_buf, host_data_en, step_en, step_buffered, done, status_vld;
	logic [7:0] ctl_byte = 8'h00, nfail = 8'h00, fmt_byte, st;
	logic [5:0] sector_in = 6'h00;
	logic [4:0] head_in = 5'h00;
	logic [11:0] lba_out;
	dcc_res_t res, fail_kind = 4'h1;
	int error_cnt = 0, checks_done = 0;
	int nnext = 0;

	always #20 clock = ~clock;

	dcc_ctl_status #(.SLOW_CYC(20)) u_dcc_ctl_status (.clock(clock), .rst_n(rst_n),
		.ctl_byte_vld(ctl_byte_vld), .ctl_byte(ctl_byte), .cmd_is_read(cmd_is_read),
		.cmd_is_format(cmd_is_format), .cmd_has_retry(has_retry), .cmd_lun(cmd_lun),
		.sector_in(sector_in), .head_in(head_in), .sectors_per_track_jumper_high(jh),
		.sectors_per_track_jumper_low(jl), .res_vld(res_vld), .res(res),
		.last_block(last_block), .seek_run(seek_run), .retry_req(retry_req),
		.recal_req(recal_req), .next_block(next_block), .send_corrected(send_corrected),
		.fmt_from_buf(fmt_from_buf), .host_data_en(host_data_en), .fmt_byte(fmt_byte),
		.lba_out(lba_out), .step_en(step_en), .step_buffered(step_buffered),
		.done(done), .status_vld(status_vld), .completion_status_byte(st));
	dcc_media_model u_dcc_media_model (.clock(clock), .rst_n(rst_n), .go(go),
		.nblk(nblk), .nfail(nfail), .fail_kind(fail_kind), .retry_req(retry_req),
		.recal_req(recal_req), .next_block(next_block), .res_vld(res_vld), .res(res),
		.last_block(last_block));

	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude

	task automatic chk(input logic ok, input string msg);
		checks_done++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask : chk

	task automatic tick;
		@(posedge clock);
		#1;
	endtask : tick

	// control byte goes last, after the other block fields are set up
	task automatic run_cmd(input logic [7:0] cb, input logic rd, input logic [7:0] nf,
		input dcc_res_t fk, output int nret, output int nrec, output int ncor);
		int i;
		nret = 0;
		nrec = 0;
		ncor = 0;
		nnext = 0;
		ctl_byte = cb;
		cmd_is_read = rd;
		nfail = nf;
		fail_kind = fk;
		ctl_byte_vld = 1'b1;
		go = 1'b1;
		tick;
		ctl_byte_vld = 1'b0;
		go = 1'b0;
		for (i = 0; i < 400 && done !== 1'b1; i++) begin
			tick;
			nret += retry_req;
			nrec += recal_req;
			ncor += send_corrected;
			nnext += next_block;
		end
		if (i >= 400) begin
			chk(1'b0, "command never completed");
			conclude();
		end
		chk(status_vld === 1'b1, "status not valid with done");
	endtask : run_cmd

	// expected status from lun, recovery class and error flag
	function automatic logic [7:0] exp_st(input logic err, input logic [1:0] rec);
		return {2'b00, cmd_lun, 1'b0, rec, err, 1'b0};
	endfunction : exp_st

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_retry;
		int a, b, c;
		cmd_lun = 1'b1;
		run_cmd(8'h80, 1'b0, 8'd99, 4'h1, a, b, c);
		chk(a == 0 && b == 0, "retry with retries disabled");
		chk(st === exp_st(1'b1, 2'b00), "status after first error");
		cmd_lun = 1'b0;
		run_cmd(8'h00, 1'b0, 8'd99, 4'h1, a, b, c);
		chk(a == 8 && b == 1, "retry plan not four, recal, four");
		chk(st === exp_st(1'b1, 2'b00), "no error after failed retries");
		run_cmd(8'h00, 1'b1, 8'd1, 4'h1, a, b, c);
		chk(a == 1 && st === exp_st(1'b0, 2'b01), "one retry recovery");
		run_cmd(8'h00, 1'b1, 8'd3, 4'h1, a, b, c);
		chk(st === exp_st(1'b0, 2'b10), "several retry recovery");
		has_retry = 1'b0;
		run_cmd(8'h00, 1'b0, 8'd99, 4'h1, a, b, c);
		chk(a == 0 && b == 0 && st === exp_st(1'b1, 2'b00), "retry without retries");
		has_retry = 1'b1;
		nblk = 8'h02;
		run_cmd(8'h00, 1'b1, 8'd2, 4'h1, a, b, c);
		chk(a == 2 && nnext == 1 && st === exp_st(1'b0, 2'b10), "next block, worst");
		nblk = 8'h01;
		run_cmd(8'h00, 1'b1, 8'd0, 4'h1, a, b, c);
		chk(st === 8'h00, "clean status");
	endtask : t_retry

	task automatic t_ecc;
		int a, b, c;
		run_cmd(8'h00, 1'b1, 8'd1, 4'h4, a, b, c);
		chk(c == 1 && st === exp_st(1'b0, 2'b11), "correction not reported");
		run_cmd(8'h40, 1'b1, 8'd99, 4'h4, a, b, c);
		chk(a == 8 && c == 1 && st[1] === 1'b1, "ecc end after retries");
		run_cmd(8'hc0, 1'b1, 8'd1, 4'h4, a, b, c);
		chk(st[1] === 1'b1 && c == 1, "ecc disabled end or corrected data");
		run_cmd(8'h00, 1'b1, 8'd99, 4'h2, a, b, c);
		chk(st[1] === 1'b1, "uncorrectable error not reported");
	endtask : t_ecc

	task automatic t_format;
		int a, b, c;
		cmd_is_format = 1'b1;
		run_cmd(8'h40, 1'b0, 8'd0, 4'h1, a, b, c); // host buffer load assumed done
		chk(fmt_from_buf === 1'b1 && host_data_en === 1'b0, "buffer format");
		run_cmd(8'h00, 1'b0, 8'd0, 4'h1, a, b, c);
		chk(fmt_from_buf === 1'b0 && fmt_byte === 8'h6c, "fixed pattern");
		cmd_is_format = 1'b0;
	endtask : t_format

	task automatic t_conv;
		int a, b, c;
		head_in = 5'h02;
		sector_in = 6'h03;
		jl = 1'b1;
		run_cmd(8'h20, 1'b0, 8'd0, 4'h1, a, b, c); // head count set elsewhere
		chk(lba_out === 12'd55, "conversion 26 sectors");
		jh = 1'b1;
		head_in = 5'h05;
		sector_in = 6'h07;
		run_cmd(8'h20, 1'b0, 8'd0, 4'h1, a, b, c);
		chk(lba_out === 12'd177, "conversion 34 sectors");
		run_cmd(8'h00, 1'b0, 8'd0, 4'h1, a, b, c);
		chk(lba_out === 12'd7, "address altered without conversion");
	endtask : t_conv

	// step periods in 40 ns cycles; slow codes use the shortened count
	task automatic t_step;
		int k, i, n;
		logic [2:0] code[8] = '{3'd0, 3'd3, 3'd2, 3'd5, 3'd4, 3'd7, 3'd6, 3'd1};
		int per[8] = '{250, 625, 1250, 5000, 1750, 20, 20, 20};
		for (k = 0; k < 8; k++) begin
			run_cmd({5'b10000, code[k]}, 1'b0, 8'd0, 4'h1, i, n, n);
			seek_run = 1'b1;
			for (i = 0; i < 6000 && step_en !== 1'b1; i++) tick;
			tick;
			for (n = 1; n < 6000 && step_en !== 1'b1; n++) tick;
			if (i >= 6000 || n >= 6000) begin
				chk(1'b0, "step pulse never came");
				conclude();
			end
			chk(n >= per[k] && n <= per[k] + 1, "step period");
			chk(step_buffered === (k < 5), "step buffering");
			seek_run = 1'b0;
		end
	endtask : t_step

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clock);
		#1;
		chk(st === 8'h00 && status_vld === 1'b0 && host_data_en === 1'b1, "reset");
		rst_n = 1'b1;
		tick;
		t_retry();
		t_ecc();
		t_format();
		t_conv();
		t_step();
		conclude();
	end
endmodule : testbench
